// *** link_port.sv ***
// Link-level packet and link maintenance logic of one serial port
// Function
// [RULE1] Flow maps to priority and critical flow bit: D 1/1, C 1/0, B 0/1, A 0/0.
// [RULE2] Packets of same priority and critical flow keep their order.
// [RULE3] A lower priority packet never overtakes a higher priority one.
// [RULE4] Under congestion a critical packet may pass equal priority non-critical ones.
// [RULE5] Software write sends a link-request; only one outstanding at a time.
// [RULE6] Receiver answers a link-request with link-response when the command needs it.
// [RULE7] Host polls the link-response register with reads.
// [RULE8] Each serial interface has its own request and response register pair.
// [RULE9] Reset-device acts after four in a row, status only between; no response.
// [RULE10] Input-status while error-stopped restarts input after the response.
// [RULE11] Input-status also restarts a receiver waiting after a retry.
// [RULE12] Input-status answer carries port state and expected sequence id.
// [RULE13] Retry-stopped left on restart-from-retry or input-status.
// [RULE14] Error-stopped left only on input-status.
// [RULE15] Every received packet is acknowledged with a control symbol; here only packets received in RX_OK are, stop states drop them unanswered.
// [RULE16] Sequence ids tag packets, increase by one and wrap to zero.
// [RULE17] A copy of each sent packet stays until accepted or judged lost.
// [RULE18] Packets accepted only in order: next id is previous plus one mod 32.
// [RULE19] Error-free packet accepted or retried by buffer space at its priority.
// [RULE20] A packet may be cancelled at any point of its transmission.
// [RULE21] Packet error coverage kept through the port: CRC passes unchanged.
// [RULE22] Sequence id is five bits and starts at zero after reset.
// [RULE23] Never more than thirty-one unacknowledged packets outstanding.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`include "link_port_defs.svh"
module link_port #(
  parameter int DATA_W = 32
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic                      src_valid,
  input  wire logic [DATA_W-1:0]         src_data,
  input  wire logic [2:0]                src_flow,
  output logic                           src_ack,
  input  wire logic                      tx_cong,
  output logic                           lk_tx_valid,
  output logic      [DATA_W-1:0]         lk_tx_data,
  output logic      [4:0]                lk_tx_ack_id,
  output logic      [1:0]                lk_tx_prio,
  output logic                           lk_tx_cfb,
  output logic                           lk_tx_cancel,
  output logic                           cs_tx_valid,
  output link_port_pkg::cs_kind_t        cs_tx_kind,
  output logic      [4:0]                cs_tx_ack_id,
  output logic      [4:0]                cs_tx_arg,
  input  wire logic                      lk_rx_valid,
  input  wire logic [DATA_W-1:0]         lk_rx_data,
  input  wire logic [4:0]                lk_rx_ack_id,
  input  wire logic [1:0]                lk_rx_prio,
  input  wire logic                      lk_rx_cfb,
  input  wire logic                      lk_rx_err,
  input  wire logic [3:0]                rx_space,
  input  wire logic                      cs_rx_valid,
  input  wire link_port_pkg::cs_kind_t   cs_rx_kind,
  input  wire logic [4:0]                cs_rx_ack_id,
  input  wire logic [4:0]                cs_rx_arg,
  output logic                           dlv_valid,
  output logic      [DATA_W-1:0]         dlv_data,
  output logic      [1:0]                dlv_prio,
  output logic                           dlv_cfb,
  output logic                           dev_reset
);
  localparam int WW = DATA_W + 3;

  // Flow to {critical flow bit, priority}; without critical flows C and up share priority 2
  function automatic logic [2:0] flow_map(input logic [2:0] flow, input logic cfb_on);
    logic [2:0] m;
    m = 3'h0;
    if (!cfb_on) begin
      m = (flow >= 3'h2) ? 3'h2 : {2'h0, flow[0]};
    end else if (flow < 3'h4) begin
      m = {flow[0], 1'b0, flow[1]}; // [RULE1]
    end else begin
      m = {(flow != 3'h4), 2'h2};
    end
    return m;
  endfunction

  link_port_pkg::tx_state_t tx_st_r, tx_st_nxt;
  link_port_pkg::rx_state_t rx_st_r, rx_st_nxt;
  link_port_pkg::cs_kind_t  cs_kind_nxt, rsp_kind;
  logic [4:0]        alloc_r, alloc_nxt, send_r, send_nxt, old_r, old_nxt;
  logic [4:0]        rd_id_r, rd_id_nxt, exp_r, exp_nxt, outstanding;
  logic [4:0]        lreq_cmd_r, lreq_cmd_nxt, cs_id_nxt, cs_arg_nxt, rsp_id, rsp_arg;
  logic [4:0]        lk_id_nxt, lresp_st_r, lresp_id_r;
  logic [1:0]        park_prio_r, park_prio_nxt, rdev_cnt_r, rdev_cnt_nxt;
  logic [DATA_W-1:0] park_data_r, park_data_nxt;
  logic [WW-1:0]     new_word, lk_word_nxt, mem_q;
  logic [2:0]        src_map;
  logic park_v_r, park_v_nxt, park_cfb_r, park_cfb_nxt, replay_rd_r, replay_rd_nxt;
  logic restart_pend_r, restart_pend_nxt, lreq_pend_r, lreq_pend_nxt;
  logic lreq_out_r, lreq_out_nxt, cfb_en_r, lresp_v_r, rsp_v, new_send;
  logic src_ack_nxt, lk_valid_nxt, cancel_nxt, cs_valid_nxt, dlv_valid_nxt;
  logic dev_reset_nxt, src_pass, src_take, win_open, replaying;
  logic ctrl_wr, lreq_wr, flush, ack_in;

  assign ctrl_wr     = reg_wr && (reg_addr == `REG_CTRL);
  assign lreq_wr     = reg_wr && (reg_addr == `REG_LREQ);
  assign flush       = ctrl_wr && reg_wdata[`CTRL_FLUSH];
  assign outstanding = alloc_r - old_r;
  assign win_open    = (outstanding != `MAX_OUTSTANDING); // [RULE23]
  assign replaying   = (send_r != alloc_r);
  assign src_map     = flow_map(src_flow, cfb_en_r);
  assign src_take    = src_valid && !src_ack;
  // A waiting packet may be passed only by higher priority or by critical flow at its level
  assign src_pass    = (src_map[1:0] > park_prio_r) ||
                       ((src_map[1:0] == park_prio_r) && src_map[2] && !park_cfb_r); // [RULE3] [RULE4]

  retry_store #(.WIDTH(WW), .DEPTH(32), .AW(5)) u_store (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .wr_en   (new_send),
    .wr_addr (alloc_r),
    .wr_data (new_word),
    .rd_addr (send_r),
    .rd_data (mem_q)
  );

  // Receive side: in-order acceptance, stop states and link-request handling
  always_comb begin
    rx_st_nxt     = rx_st_r;
    exp_nxt       = exp_r;
    rdev_cnt_nxt  = rdev_cnt_r;
    dev_reset_nxt = 1'b0;
    dlv_valid_nxt = 1'b0;
    rsp_v         = 1'b0;
    rsp_kind      = link_port_pkg::CS_NONE;
    rsp_id        = lk_rx_ack_id;
    rsp_arg       = 5'h00;
    if (lk_rx_valid) begin
      rdev_cnt_nxt = 2'h0;
      if (rx_st_r == link_port_pkg::RX_OK) begin
        rsp_v = 1'b1; // [RULE15]
        if (lk_rx_err || (lk_rx_ack_id != exp_r)) begin
          rsp_kind  = link_port_pkg::CS_NOT_ACCEPTED; // [RULE18]
          rx_st_nxt = link_port_pkg::RX_ERR_STOP;
        end else if (rx_space[lk_rx_prio]) begin
          rsp_kind      = link_port_pkg::CS_ACCEPTED; // [RULE19]
          dlv_valid_nxt = 1'b1;
          exp_nxt       = exp_r + 5'h01; // [RULE18]
        end else begin
          rsp_kind  = link_port_pkg::CS_RETRY; // [RULE19]
          rx_st_nxt = link_port_pkg::RX_RETRY_STOP;
        end
      end
    end else if (cs_rx_valid) begin
      if (cs_rx_kind != link_port_pkg::CS_STATUS) begin
        rdev_cnt_nxt = 2'h0;
      end
      if (cs_rx_kind == link_port_pkg::CS_LINK_REQ && cs_rx_arg == `CMD_RESET_DEV) begin
        // Lockout against a spurious reset: only the fourth in a row acts, no answer
        rdev_cnt_nxt = rdev_cnt_r + 2'h1; // [RULE9]
        if (rdev_cnt_r == `RESET_DEV_REPS) begin
          dev_reset_nxt = 1'b1; // [RULE9]
          rdev_cnt_nxt  = 2'h0;
        end
      end else if (cs_rx_kind == link_port_pkg::CS_LINK_REQ &&
                   cs_rx_arg == `CMD_INPUT_STAT) begin
        rsp_v     = 1'b1; // [RULE6]
        rsp_kind  = link_port_pkg::CS_LINK_RESP;
        rsp_id    = exp_r; // [RULE12]
        rsp_arg   = (rx_st_r == link_port_pkg::RX_OK) ? `PST_OK :
                    (rx_st_r == link_port_pkg::RX_RETRY_STOP) ? `PST_RETRY_STOP :
                    `PST_ERR_STOP; // [RULE12]
        rx_st_nxt = link_port_pkg::RX_OK; // [RULE10] [RULE11] [RULE14]
      end else if (cs_rx_kind == link_port_pkg::CS_RESTART &&
                   rx_st_r == link_port_pkg::RX_RETRY_STOP) begin
        rx_st_nxt = link_port_pkg::RX_OK; // [RULE13]
      end
    end
  end

  // Registers of the receive side; delivered words are passed on untouched
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_st_r    <= link_port_pkg::RX_OK;
      exp_r      <= 5'h00;
      rdev_cnt_r <= 2'h0;
      dev_reset  <= 1'b0;
      dlv_valid  <= 1'b0;
      dlv_data   <= '0;
      dlv_prio   <= 2'h0;
      dlv_cfb    <= 1'b0;
    end else if (clk_en) begin
      rx_st_r    <= rx_st_nxt;
      exp_r      <= exp_nxt;
      rdev_cnt_r <= rdev_cnt_nxt;
      dev_reset  <= dev_reset_nxt;
      dlv_valid  <= dlv_valid_nxt;
      dlv_data   <= lk_rx_data; // [RULE21]
      dlv_prio   <= lk_rx_prio;
      dlv_cfb    <= lk_rx_cfb;
    end
  end

  // Transmit side: id assignment, parking under congestion, replay and symbol output
  always_comb begin
    alloc_nxt        = alloc_r;
    send_nxt         = send_r;
    old_nxt          = old_r;
    tx_st_nxt        = tx_st_r;
    park_v_nxt       = park_v_r;
    park_data_nxt    = park_data_r;
    park_prio_nxt    = park_prio_r;
    park_cfb_nxt     = park_cfb_r;
    restart_pend_nxt = restart_pend_r;
    lreq_pend_nxt    = lreq_pend_r;
    lreq_out_nxt     = lreq_out_r;
    lreq_cmd_nxt     = lreq_cmd_r;
    src_ack_nxt      = 1'b0;
    replay_rd_nxt    = 1'b0;
    rd_id_nxt        = send_r;
    new_send         = 1'b0;
    new_word         = {park_cfb_r, park_prio_r, park_data_r};
    lk_valid_nxt     = 1'b0;
    lk_id_nxt        = lk_tx_ack_id;
    lk_word_nxt      = {lk_tx_cfb, lk_tx_prio, lk_tx_data};
    cs_valid_nxt     = 1'b0;
    cs_kind_nxt      = cs_tx_kind;
    cs_id_nxt        = cs_tx_ack_id;
    cs_arg_nxt       = cs_tx_arg;
    ack_in           = cs_rx_valid && !lk_rx_valid;
    // Packet in flight is aborted once the partner has refused the stream
    cancel_nxt = lk_tx_valid && ack_in && (cs_rx_kind == link_port_pkg::CS_RETRY ||
                 cs_rx_kind == link_port_pkg::CS_NOT_ACCEPTED); // [RULE20]
    if (tx_st_r == link_port_pkg::TX_OK && replaying) begin
      replay_rd_nxt = 1'b1; // [RULE17]
      send_nxt      = send_r + 5'h01;
    end else if (tx_st_r == link_port_pkg::TX_OK && win_open && !replay_rd_r) begin
      if (park_v_r && !tx_cong) begin
        new_send   = 1'b1; // [RULE2]
        park_v_nxt = 1'b0;
      end else if (src_take && park_v_r) begin
        if (src_pass) begin
          new_send    = 1'b1; // [RULE4]
          src_ack_nxt = 1'b1;
          new_word    = {src_map, src_data};
        end
      end else if (src_take) begin
        src_ack_nxt = 1'b1;
        if (tx_cong && !src_map[2]) begin
          park_v_nxt    = 1'b1;
          park_data_nxt = src_data;
          park_prio_nxt = src_map[1:0];
          park_cfb_nxt  = src_map[2];
        end else begin
          new_send = 1'b1;
          new_word = {src_map, src_data};
        end
      end
    end
    if (new_send) begin
      alloc_nxt    = alloc_r + 5'h01; // [RULE16]
      send_nxt     = send_r + 5'h01;
      lk_valid_nxt = 1'b1;
      lk_id_nxt    = alloc_r; // [RULE16]
      lk_word_nxt  = new_word;
    end
    if (replay_rd_r && tx_st_r == link_port_pkg::TX_OK) begin
      lk_valid_nxt = 1'b1;
      lk_id_nxt    = rd_id_r;
      lk_word_nxt  = mem_q;
    end
    // Answers to the partner go first; own requests wait for a free slot
    if (rsp_v) begin
      cs_valid_nxt = 1'b1; // [RULE15]
      cs_kind_nxt  = rsp_kind;
      cs_id_nxt    = rsp_id;
      cs_arg_nxt   = rsp_arg;
    end else if (restart_pend_r) begin
      cs_valid_nxt     = 1'b1;
      cs_kind_nxt      = link_port_pkg::CS_RESTART;
      cs_arg_nxt       = 5'h00;
      restart_pend_nxt = 1'b0;
      tx_st_nxt        = link_port_pkg::TX_OK;
    end else if (lreq_pend_r) begin
      cs_valid_nxt  = 1'b1; // [RULE5]
      cs_kind_nxt   = link_port_pkg::CS_LINK_REQ;
      cs_arg_nxt    = lreq_cmd_r;
      lreq_pend_nxt = 1'b0;
      lreq_out_nxt  = (lreq_cmd_r == `CMD_INPUT_STAT);
    end
    if (lreq_wr && !lreq_pend_r && !lreq_out_r) begin
      lreq_pend_nxt = 1'b1; // [RULE5]
      lreq_cmd_nxt  = reg_wdata[4:0];
    end
    if (flush) begin
      // Copies judged lost are dropped; transmission restarts at the next new id
      old_nxt   = alloc_r; // [RULE17]
      send_nxt  = alloc_r;
      tx_st_nxt = link_port_pkg::TX_OK;
    end
    if (ack_in) begin
      case (cs_rx_kind)
        link_port_pkg::CS_ACCEPTED: begin
          if (cs_rx_ack_id == old_r && old_r != alloc_r) begin
            old_nxt = old_r + 5'h01; // [RULE17]
          end
        end
        link_port_pkg::CS_RETRY: begin
          tx_st_nxt        = link_port_pkg::TX_RETRY_STOP;
          send_nxt         = cs_rx_ack_id;
          replay_rd_nxt    = 1'b0;
          restart_pend_nxt = 1'b1;
        end
        link_port_pkg::CS_NOT_ACCEPTED: begin
          tx_st_nxt     = link_port_pkg::TX_ERR_STOP;
          replay_rd_nxt = 1'b0;
          if (!lreq_out_r) begin
            lreq_pend_nxt = 1'b1;
            lreq_cmd_nxt  = `CMD_INPUT_STAT;
          end
        end
        link_port_pkg::CS_LINK_RESP: begin
          if (lreq_out_r) begin
            lreq_out_nxt = 1'b0;
            if (tx_st_r == link_port_pkg::TX_ERR_STOP) begin
              old_nxt   = cs_rx_ack_id;
              send_nxt  = cs_rx_ack_id;
              tx_st_nxt = link_port_pkg::TX_OK;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Registers of the transmit side
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alloc_r        <= 5'h00; // [RULE22]
      send_r         <= 5'h00;
      old_r          <= 5'h00;
      rd_id_r        <= 5'h00;
      tx_st_r        <= link_port_pkg::TX_OK;
      park_v_r       <= 1'b0;
      park_data_r    <= '0;
      park_prio_r    <= 2'h0;
      park_cfb_r     <= 1'b0;
      replay_rd_r    <= 1'b0;
      restart_pend_r <= 1'b0;
      lreq_pend_r    <= 1'b0;
      lreq_out_r     <= 1'b0;
      lreq_cmd_r     <= 5'h00;
      src_ack        <= 1'b0;
      lk_tx_valid    <= 1'b0;
      lk_tx_ack_id   <= 5'h00;
      {lk_tx_cfb, lk_tx_prio, lk_tx_data} <= '0;
      lk_tx_cancel   <= 1'b0;
      cs_tx_valid    <= 1'b0;
      cs_tx_kind     <= link_port_pkg::CS_NONE;
      cs_tx_ack_id   <= 5'h00;
      cs_tx_arg      <= 5'h00;
    end else if (clk_en) begin
      alloc_r        <= alloc_nxt;
      send_r         <= send_nxt;
      old_r          <= old_nxt;
      rd_id_r        <= rd_id_nxt;
      tx_st_r        <= tx_st_nxt;
      park_v_r       <= park_v_nxt;
      park_data_r    <= park_data_nxt;
      park_prio_r    <= park_prio_nxt;
      park_cfb_r     <= park_cfb_nxt;
      replay_rd_r    <= replay_rd_nxt;
      restart_pend_r <= restart_pend_nxt;
      lreq_pend_r    <= lreq_pend_nxt;
      lreq_out_r     <= lreq_out_nxt;
      lreq_cmd_r     <= lreq_cmd_nxt;
      src_ack        <= src_ack_nxt;
      lk_tx_valid    <= lk_valid_nxt;
      lk_tx_ack_id   <= lk_id_nxt;
      {lk_tx_cfb, lk_tx_prio, lk_tx_data} <= lk_word_nxt;
      lk_tx_cancel   <= cancel_nxt;
      cs_tx_valid    <= cs_valid_nxt;
      cs_tx_kind     <= cs_kind_nxt;
      cs_tx_ack_id   <= cs_id_nxt;
      cs_tx_arg      <= cs_arg_nxt;
    end
  end

  // Register port: this instance owns one request/response pair; reading the response clears it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfb_en_r   <= `CTRL_RESET;
      lresp_v_r  <= 1'b0;
      lresp_st_r <= 5'h00;
      lresp_id_r <= 5'h00;
      reg_rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        cfb_en_r <= reg_wdata[`CTRL_CFB_EN];
      end
      if (ack_in && cs_rx_kind == link_port_pkg::CS_LINK_RESP && lreq_out_r) begin
        lresp_v_r  <= 1'b1; // [RULE8]
        lresp_st_r <= cs_rx_arg;
        lresp_id_r <= cs_rx_ack_id;
      end else if (reg_rd && reg_addr == `REG_LRESP) begin
        lresp_v_r <= 1'b0; // [RULE7]
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL:   reg_rdata <= {31'h0, cfb_en_r};
          `REG_LREQ:   reg_rdata <= {27'h0, lreq_cmd_r};
          `REG_LRESP:  reg_rdata <= {lresp_v_r, lreq_pend_r | lreq_out_r, 20'h0,
                                     lresp_st_r, lresp_id_r}; // [RULE7]
          `REG_STATUS: reg_rdata <= {4'h0, tx_st_r, rx_st_r, 3'h0, outstanding,
                                     3'h0, alloc_r, 3'h0, exp_r};
          default:     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks, sampled only on enabled edges
  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!resetn);

  a_window_limit: assert property (lk_tx_valid |-> outstanding <= `MAX_OUTSTANDING) // [RULE23]
    else $error("more than thirty-one packets outstanding");
  a_new_id_seq: assert property (new_send |=> lk_tx_valid && lk_tx_ack_id == $past(alloc_r)) // [RULE16]
    else $error("new packet id not the allocated one");
  a_in_order: assert property (dlv_valid |-> exp_r == 5'($past(exp_r, 2) + 5'h01)
    || !$past(dlv_valid) ) // [RULE18]
    else $error("accepted packet out of sequence");
  a_every_ack: assert property ((lk_rx_valid && rx_st_r == link_port_pkg::RX_OK) |=>
    cs_tx_valid && cs_tx_kind inside {link_port_pkg::CS_ACCEPTED, link_port_pkg::CS_RETRY,
    link_port_pkg::CS_NOT_ACCEPTED}) // [RULE15]
    else $error("received packet not acknowledged");
  a_retry_stop: assert property ((lk_rx_valid && rx_st_r == link_port_pkg::RX_OK && !lk_rx_err
    && lk_rx_ack_id == exp_r && !rx_space[lk_rx_prio]) |=>
    rx_st_r == link_port_pkg::RX_RETRY_STOP && cs_tx_kind == link_port_pkg::CS_RETRY) // [RULE19]
    else $error("no buffer space did not retry");
  a_err_hold: assert property ((rx_st_r == link_port_pkg::RX_ERR_STOP && !lk_rx_valid &&
    !(cs_rx_valid && cs_rx_kind == link_port_pkg::CS_LINK_REQ)) |=>
    rx_st_r == link_port_pkg::RX_ERR_STOP) // [RULE14]
    else $error("error stop left without input-status");
  a_input_status: assert property ((!lk_rx_valid && cs_rx_valid && cs_rx_arg == `CMD_INPUT_STAT
    && cs_rx_kind == link_port_pkg::CS_LINK_REQ) |=> cs_tx_valid && rx_st_r == link_port_pkg::RX_OK
    && cs_tx_kind == link_port_pkg::CS_LINK_RESP && cs_tx_ack_id == $past(exp_r)) // [RULE12]
    else $error("input-status answer wrong or late");
  a_reset_lockout: assert property (dev_reset |-> $past(rdev_cnt_r) == `RESET_DEV_REPS) // [RULE9]
    else $error("device reset before four requests");
  a_one_request: assert property (lreq_out_r |=>
    !(cs_tx_valid && cs_tx_kind == link_port_pkg::CS_LINK_REQ)) // [RULE5]
    else $error("second link-request while one outstanding");

  c_retry_recover: cover property (rx_st_r == link_port_pkg::RX_RETRY_STOP ##[1:20]
    rx_st_r == link_port_pkg::RX_OK);
  c_device_reset: cover property (dev_reset);
  c_replay: cover property (replay_rd_r && lk_tx_valid);
  c_crit_pass: cover property (park_v_r && new_send && src_ack_nxt);
endmodule

// *** link_port_defs.svh ***
// Register offsets, field positions and protocol constants of the link port
`ifndef LINK_PORT_DEFS_SVH
`define LINK_PORT_DEFS_SVH
`define REG_CTRL        8'h00
`define REG_LREQ        8'h04
`define REG_LRESP       8'h08
`define REG_STATUS      8'h0c
`define CTRL_CFB_EN     0
`define CTRL_FLUSH      1
`define CTRL_RESET      1'h1
`define LRESP_VALID     31
`define LRESP_PEND      30
`define MAX_OUTSTANDING 5'h1f
`define RESET_DEV_REPS  2'h3
`define CMD_RESET_DEV   5'h03
`define CMD_INPUT_STAT  5'h04
`define PST_OK          5'h10
`define PST_RETRY_STOP  5'h04
`define PST_ERR_STOP    5'h05
`endif

// *** link_port_pkg.sv ***
// Types shared by the link port: control symbol kinds and port states
package link_port_pkg;
  typedef enum logic [2:0] {
    CS_NONE, CS_ACCEPTED, CS_RETRY, CS_NOT_ACCEPTED,
    CS_RESTART, CS_LINK_REQ, CS_LINK_RESP, CS_STATUS
  } cs_kind_t;
  typedef enum logic [1:0] {RX_OK, RX_RETRY_STOP, RX_ERR_STOP} rx_state_t;
  typedef enum logic [1:0] {TX_OK, TX_RETRY_STOP, TX_ERR_STOP} tx_state_t;
endpackage

// *** retry_store.sv ***
// Copy store of sent packets awaiting acceptance, registered read port
`timescale 1ns/1ns
module retry_store #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset so the array maps onto plain RAM
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// *** link_peer.sv ***
// Link partner model: accepts every sent packet unless a symbol is injected in the same cycle, and forwards injected symbols
`timescale 1ns/1ns
module link_peer (
  input  wire logic                    clk_sys,
  input  wire logic                    lk_tx_valid,
  input  wire logic [4:0]              lk_tx_ack_id,
  input  wire logic                    inj_valid,
  input  wire link_port_pkg::cs_kind_t inj_kind,
  input  wire logic [4:0]              inj_arg,
  output logic                         cs_rx_valid,
  output link_port_pkg::cs_kind_t      cs_rx_kind,
  output logic      [4:0]              cs_rx_ack_id,
  output logic      [4:0]              cs_rx_arg
);
  initial {cs_rx_valid, cs_rx_ack_id, cs_rx_arg} = '0;
  initial cs_rx_kind = link_port_pkg::CS_NONE;
  // Idle fields toggle so that a stale value never passes for a fresh one
  always @(posedge clk_sys) begin
    cs_rx_valid  <= inj_valid | lk_tx_valid;
    cs_rx_kind   <= inj_valid ? inj_kind : lk_tx_valid ? link_port_pkg::CS_ACCEPTED
                                                       : link_port_pkg::CS_NONE;
    cs_rx_ack_id <= lk_tx_valid ? lk_tx_ack_id : ~cs_rx_ack_id;
    cs_rx_arg    <= inj_valid ? inj_arg : ~cs_rx_arg;
  end
endmodule

// *** link_port_tb.sv ***
// Self-checking bench for the link port against a symbol-level partner
`timescale 1ns/1ns
module link_port_tb;
  logic                    clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, src_valid = 0;
  logic                    lk_rx_valid = 0, lk_rx_cfb = 0, lk_rx_err = 0, inj_valid = 0;
  logic [7:0]              reg_addr = 0;
  logic [31:0]             reg_wdata = 0, src_data = 0, lk_rx_data = 0;
  logic [31:0]             reg_rdata, lk_tx_data, dlv_data;
  logic [2:0]              src_flow = 0;
  logic [4:0]              lk_rx_ack_id = 0, inj_arg = 0, lk_tx_ack_id, cs_tx_ack_id;
  logic [4:0]              cs_tx_arg, cs_rx_ack_id, cs_rx_arg;
  logic [1:0]              lk_rx_prio = 0, lk_tx_prio, dlv_prio;
  logic [3:0]              rx_space = 0;
  logic                    src_ack, lk_tx_valid, lk_tx_cfb, cs_tx_valid, cs_rx_valid;
  logic                    dlv_valid, dlv_cfb, dev_reset;
  link_port_pkg::cs_kind_t inj_kind = link_port_pkg::CS_NONE, cs_tx_kind, cs_rx_kind;
  int                      n, n_fail = 0, checked = 0;
  // Ordinary inbound cases: {id, priority, free space}, each fits its priority
  logic [10:0]             rows [3] = '{{5'd0, 2'd0, 4'hf}, {5'd1, 2'd3, 4'h8},
                                        {5'd2, 2'd1, 4'h2}};
  link_port uut (.*, .clk_en(1'b1), .tx_cong(1'b0), .lk_tx_cancel());
  link_peer peer (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // A bounded wait that runs out counts a mismatch and ends the run
  task automatic tmo;
    if (n == 8) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wcs(input link_port_pkg::cs_kind_t k);
    #1;
    for (n = 0; n < 8 && cs_tx_valid !== 1'b1; n++) @(posedge clk_sys) #1;
    tmo();
    chk(cs_tx_kind, k);
  endtask
  // Strobes stand one cycle; read data is taken in the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) reg_rd <= 0;
    #1;
  endtask
  task automatic inj(input link_port_pkg::cs_kind_t k, input logic [4:0] a);
    @(posedge clk_sys) inj_kind <= k;
    {inj_valid, inj_arg} <= {1'b1, a};
    @(posedge clk_sys) inj_valid <= 0;
  endtask
  // Source holds the packet until acknowledged, then drops it at the next edge
  task automatic tx(input logic [2:0] f);
    @(posedge clk_sys) {src_valid, src_flow, src_data} <= {1'b1, f, 29'h0, f};
    for (n = 0; n < 8 && src_ack !== 1'b1; n++) @(posedge clk_sys) #1;
    tmo();
    chk({lk_tx_valid, lk_tx_prio, lk_tx_cfb, lk_tx_ack_id}, {2'b10, f[1], f[0], 2'b0, f});
    chk(lk_tx_data, {29'h0, f});
    @(posedge clk_sys) src_valid <= 0;
  endtask
  task automatic rx(input logic [10:0] r, input link_port_pkg::cs_kind_t k);
    @(posedge clk_sys) {lk_rx_valid, lk_rx_ack_id, lk_rx_prio, rx_space, lk_rx_data} <=
      {1'b1, r, 27'h0, r[10:6]};
    @(posedge clk_sys) lk_rx_valid <= 0;
    wcs(k);
    chk({cs_tx_ack_id, dlv_valid}, {r[10:6], k == link_port_pkg::CS_ACCEPTED});
    if (dlv_valid === 1'b1) chk({dlv_prio, dlv_data[4:0]}, {r[5:4], r[10:6]});
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    rd(8'h0c);
    chk({reg_rdata[27:24], reg_rdata[12:8], reg_rdata[4:0]}, 0);
    rd(8'h00);
    chk(reg_rdata[0], 1);
    rd(8'h10);
    chk(reg_rdata, 0);
    for (int f = 0; f < 4; f++) tx(f[2:0]);
    rd(8'h0c);
    chk(reg_rdata[20:16], 0);
    foreach (rows[i]) rx(rows[i], link_port_pkg::CS_ACCEPTED);
    rx({5'd3, 2'd1, 4'hd}, link_port_pkg::CS_RETRY);
    inj(link_port_pkg::CS_RESTART, 5'h0);
    rx({5'd3, 2'd1, 4'hf}, link_port_pkg::CS_ACCEPTED);
    rx({5'd9, 2'd0, 4'hf}, link_port_pkg::CS_NOT_ACCEPTED);
    inj(link_port_pkg::CS_RESTART, 5'h0);
    inj(link_port_pkg::CS_LINK_REQ, 5'h04);
    wcs(link_port_pkg::CS_LINK_RESP);
    chk({cs_tx_arg, cs_tx_ack_id}, {5'h05, 5'd4});
    rx({5'd4, 2'd0, 4'hf}, link_port_pkg::CS_ACCEPTED);
    for (int i = 0; i < 5; i++)
      inj(i == 2 ? link_port_pkg::CS_STATUS : link_port_pkg::CS_LINK_REQ, 5'h03);
    #1;
    for (n = 0; n < 8 && dev_reset !== 1'b1; n++) @(posedge clk_sys) #1;
    tmo();
    wr(8'h04, 32'h4);
    wcs(link_port_pkg::CS_LINK_REQ);
    chk(cs_tx_arg, 5'h04);
    inj(link_port_pkg::CS_LINK_RESP, 5'h10);
    rd(8'h08);
    chk({reg_rdata[31], reg_rdata[9:5]}, {1'b1, 5'h10});
    summarize();
  end
endmodule
